// *** cap_sense_control.sv ***
// Control for a capacitive touch sense oscillator, its channel mux and two timers.
// Assumes the analog oscillator comparator, timer pin and gate arrive asynchronously.
//
// Operation
// - Reference mode bit picks variable or fixed thresholds
// - Range codes 01/10/11 give low/medium/high current
// - Variable range code 00 is noise detection
// - Fixed range code 00 turns oscillator off
// - Enabled module connects oscillator to selected pin
// - Channels 0-11 valid; reserved or disabled select none
// - Enable bit switches oscillator, drive and channel select on/off; timers and reference selection ignore it
// - Read-only status shows source or sink
// - Status one when sourcing, zero when sinking
// - Fixed: ground/supply; variable: DAC low, FIXED_VOLTAGE_REFERENCE high
// - Timer A ext select makes oscillator its clock when the source bit is set
// - Timer B source 11 makes oscillator its clock
// - Timer B off, free running, or gated
module cap_sense_control (
  input wire logic clock,
  input wire logic reset,
  input wire logic [31:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [31:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic oscillatorComparator,
  input wire logic timerPin,
  input wire logic timerBGate,
  output logic oscillatorOn,
  output logic noiseDetect,
  output logic driveLow,
  output logic driveMedium,
  output logic driveHigh,
  output logic lowRefFromDac,
  output logic highRefFromFvr,
  output logic [11:0] channelSelect,
  output logic timerAOscClock,
  output logic timerBOscClock,
  output logic timerBRunning
);

  typedef struct packed {
    logic awReady;
    logic wReady;
    logic arReady;
    logic awHave;
    logic [7:0] awAddr;
    logic wHave;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bValid;
    logic [1:0] bResp;
    logic rValid;
    logic [31:0] rData;
    logic [1:0] rResp;
    logic enable;
    logic refVariable;
    logic [1:0] range;
    logic aExtSelect;
    logic [3:0] channel;
    logic aSource;
    logic aOverflow;
    logic [cap_sense_pkg::TIMER_A_WIDTH-1:0] aCount;
    logic [1:0] bSource;
    logic bOn;
    logic bGateEnable;
    logic [cap_sense_pkg::TIMER_B_WIDTH-1:0] bCount;
    logic [1:0] prescale;
    logic oscPrev;
    logic pinPrev;
    logic status;
    logic oscOn;
    logic noise;
    logic [2:0] drive;
    logic lowDac;
    logic highFvr;
    logic [11:0] chanSel;
    logic aOscClock;
    logic bOscClock;
    logic bRunning;
  } state_t;

  state_t s_q;
  state_t s_d;
  logic [2:0] syncOut;
  logic oscSync;
  logic pinSync;
  logic gateSync;
  logic oscRise;
  logic pinRise;
  logic quarterTick;
  logic doWrite;
  logic writeMapped;
  logic aInc;
  logic bInc;
  logic wrTimerB;

  // ==========================================================================
  // Asynchronous inputs
  // Oscillator may run far from the bus clock; edges are counted after sync
  sync_two_flop #(.WIDTH(3)) inputSync (
    .clock(clock),
    .reset(reset),
    .async({oscillatorComparator, timerPin, timerBGate}),
    .synced(syncOut)
  );

  assign oscSync = syncOut[2];
  assign pinSync = syncOut[1];
  assign gateSync = syncOut[0];
  assign oscRise = oscSync & ~s_q.oscPrev;
  assign pinRise = pinSync & ~s_q.pinPrev;
  assign quarterTick = s_q.prescale == cap_sense_pkg::PRESCALE_LAST;

  // ==========================================================================
  // Helpers
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                         input logic [3:0] strb);
    logic [31:0] result;
    result = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        result[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return result;
  endfunction : merge

  function automatic logic mapped(input logic [7:0] addr);
    return addr[7:2] <= cap_sense_pkg::TIMER_B_COUNT_OFFSET[7:2];
  endfunction : mapped

  function automatic logic [31:0] readValue(input state_t s, input logic [7:0] addr);
    logic [31:0] v;
    v = '0;
    case ({addr[7:2], 2'h0})
      cap_sense_pkg::SENSE_CONTROL_0_OFFSET: begin
        v[cap_sense_pkg::MODULE_ENABLE_BIT] = s.enable;
        v[cap_sense_pkg::REFERENCE_MODE_BIT] = s.refVariable;
        v[cap_sense_pkg::CURRENT_RANGE_LSB +: 2] = s.range;
        v[cap_sense_pkg::DRIVE_STATUS_BIT] = s.status;
        v[cap_sense_pkg::TIMER_A_EXT_SELECT_BIT] = s.aExtSelect;
      end
      cap_sense_pkg::SENSE_CONTROL_1_OFFSET: v[3:0] = s.channel;
      cap_sense_pkg::TIMER_A_CONTROL_OFFSET: begin
        v[cap_sense_pkg::TIMER_A_SOURCE_BIT] = s.aSource;
        v[cap_sense_pkg::TIMER_A_OVERFLOW_BIT] = s.aOverflow;
      end
      cap_sense_pkg::TIMER_A_COUNT_OFFSET: v[cap_sense_pkg::TIMER_A_WIDTH-1:0] = s.aCount;
      cap_sense_pkg::TIMER_B_CONTROL_OFFSET: begin
        v[cap_sense_pkg::TIMER_B_SOURCE_LSB +: 2] = s.bSource;
        v[cap_sense_pkg::TIMER_B_GATE_ENABLE_BIT] = s.bGateEnable;
        v[cap_sense_pkg::TIMER_B_ON_BIT] = s.bOn;
      end
      cap_sense_pkg::TIMER_B_COUNT_OFFSET: v[cap_sense_pkg::TIMER_B_WIDTH-1:0] = s.bCount;
      default: v = '0;
    endcase
    return v;
  endfunction : readValue

  assign doWrite = s_q.awHave & s_q.wHave & ~s_q.bValid;
  assign writeMapped = doWrite & mapped(s_q.awAddr);
  assign wrTimerB = writeMapped &
    ({s_q.awAddr[7:2], 2'h0} == cap_sense_pkg::TIMER_B_COUNT_OFFSET);

  // ==========================================================================
  // Timer clocking
  always_comb begin
    if (s_q.aSource) begin
      aInc = s_q.aExtSelect ? oscRise : pinRise;
    end else begin
      aInc = quarterTick;
    end
    case (s_q.bSource)
      cap_sense_pkg::TIMER_B_SRC_QUARTER: bInc = quarterTick;
      cap_sense_pkg::TIMER_B_SRC_SYSTEM: bInc = 1'b1;
      cap_sense_pkg::TIMER_B_SRC_PIN: bInc = pinRise;
      default: bInc = oscRise;
    endcase
    bInc = bInc & s_q.bOn & (~s_q.bGateEnable | gateSync);
  end

  // ==========================================================================
  // Next state
  always_comb begin
    logic [31:0] merged;
    logic aSet;
    merged = '0;
    aSet = 1'b0;
    s_d = s_q;
    s_d.prescale = s_q.prescale + 2'h1;
    s_d.oscPrev = oscSync;
    s_d.pinPrev = pinSync;

    if (awvalid && s_q.awReady) begin
      s_d.awHave = 1'b1;
      s_d.awAddr = awaddr[7:0];
    end
    if (wvalid && s_q.wReady) begin
      s_d.wHave = 1'b1;
      s_d.wData = wdata;
      s_d.wStrb = wstrb;
    end
    if (s_q.bValid && bready) begin
      s_d.bValid = 1'b0;
    end
    if (doWrite) begin
      s_d.awHave = 1'b0;
      s_d.wHave = 1'b0;
      s_d.bValid = 1'b1;
      s_d.bResp = mapped(s_q.awAddr) ? cap_sense_pkg::RESP_OKAY : cap_sense_pkg::RESP_SLVERR;
    end

    if (s_q.rValid && rready) begin
      s_d.rValid = 1'b0;
    end
    if (arvalid && s_q.arReady) begin
      s_d.rValid = 1'b1;
      s_d.rData = readValue(s_q, araddr[7:0]);
      s_d.rResp = mapped(araddr[7:0]) ? cap_sense_pkg::RESP_OKAY : cap_sense_pkg::RESP_SLVERR;
    end

    aSet = aInc && (s_q.aCount == '1);
    if (aInc) begin
      s_d.aCount = s_q.aCount + 1'b1;
    end
    if (bInc) begin
      s_d.bCount = s_q.bCount + 1'b1;
    end

    // Software writes beat a same-cycle count, but a set of the overflow flag wins
    if (writeMapped) begin
      merged = merge(readValue(s_q, s_q.awAddr), s_q.wData, s_q.wStrb);
      case ({s_q.awAddr[7:2], 2'h0})
        cap_sense_pkg::SENSE_CONTROL_0_OFFSET: begin
          s_d.enable = merged[cap_sense_pkg::MODULE_ENABLE_BIT];
          s_d.refVariable = merged[cap_sense_pkg::REFERENCE_MODE_BIT];
          s_d.range = merged[cap_sense_pkg::CURRENT_RANGE_LSB +: 2];
          s_d.aExtSelect = merged[cap_sense_pkg::TIMER_A_EXT_SELECT_BIT];
        end
        cap_sense_pkg::SENSE_CONTROL_1_OFFSET: s_d.channel = merged[3:0];
        cap_sense_pkg::TIMER_A_CONTROL_OFFSET: begin
          s_d.aSource = merged[cap_sense_pkg::TIMER_A_SOURCE_BIT];
          if (s_q.wStrb[0] && s_q.wData[cap_sense_pkg::TIMER_A_OVERFLOW_BIT]) begin
            s_d.aOverflow = 1'b0;
          end
        end
        cap_sense_pkg::TIMER_A_COUNT_OFFSET:
          s_d.aCount = merged[cap_sense_pkg::TIMER_A_WIDTH-1:0];
        cap_sense_pkg::TIMER_B_CONTROL_OFFSET: begin
          s_d.bSource = merged[cap_sense_pkg::TIMER_B_SOURCE_LSB +: 2];
          s_d.bGateEnable = merged[cap_sense_pkg::TIMER_B_GATE_ENABLE_BIT];
          s_d.bOn = merged[cap_sense_pkg::TIMER_B_ON_BIT];
        end
        cap_sense_pkg::TIMER_B_COUNT_OFFSET:
          s_d.bCount = merged[cap_sense_pkg::TIMER_B_WIDTH-1:0];
        default: s_d.bCount = s_d.bCount;
      endcase
    end
    if (aSet) begin
      s_d.aOverflow = 1'b1;
    end

    // Analog controls follow the registered settings one cycle later
    s_d.oscOn = s_q.enable && (s_q.refVariable || s_q.range != cap_sense_pkg::RANGE_OFF_OR_NOISE);
    s_d.noise = s_q.enable && s_q.refVariable &&
      s_q.range == cap_sense_pkg::RANGE_OFF_OR_NOISE;
    s_d.drive[0] = s_q.enable && s_q.range == cap_sense_pkg::RANGE_LOW;
    s_d.drive[1] = s_q.enable && s_q.range == cap_sense_pkg::RANGE_MEDIUM;
    s_d.drive[2] = s_q.enable && s_q.range == cap_sense_pkg::RANGE_HIGH;
    s_d.lowDac = s_q.refVariable;
    s_d.highFvr = s_q.refVariable;
    s_d.status = s_q.oscOn && !s_q.noise && oscSync;
    s_d.chanSel = '0;
    if (s_q.enable && s_q.channel <= cap_sense_pkg::LAST_CHANNEL) begin
      s_d.chanSel[s_q.channel] = 1'b1;
    end
    s_d.aOscClock = s_q.aSource && s_q.aExtSelect;
    s_d.bOscClock = s_q.bSource == cap_sense_pkg::TIMER_B_SRC_OSCILLATOR;
    s_d.bRunning = s_q.bOn;

    s_d.awReady = !s_d.awHave && !s_d.bValid;
    s_d.wReady = !s_d.wHave && !s_d.bValid;
    s_d.arReady = !s_d.rValid;
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================================
  // Outputs
  assign awready = s_q.awReady;
  assign wready = s_q.wReady;
  assign arready = s_q.arReady;
  assign bvalid = s_q.bValid;
  assign bresp = s_q.bResp;
  assign rvalid = s_q.rValid;
  assign rdata = s_q.rData;
  assign rresp = s_q.rResp;
  assign oscillatorOn = s_q.oscOn;
  assign noiseDetect = s_q.noise;
  assign driveLow = s_q.drive[0];
  assign driveMedium = s_q.drive[1];
  assign driveHigh = s_q.drive[2];
  assign lowRefFromDac = s_q.lowDac;
  assign highRefFromFvr = s_q.highFvr;
  assign channelSelect = s_q.chanSel;
  assign timerAOscClock = s_q.aOscClock;
  assign timerBOscClock = s_q.bOscClock;
  assign timerBRunning = s_q.bRunning;

  // ==========================================================================
  // Checks
  a_ref_select: assert property (@(posedge clock) disable iff (reset)
    ##1 (lowRefFromDac == $past(s_q.refVariable)) && (highRefFromFvr == lowRefFromDac))
    else $error("reference source does not follow mode bit");
  a_drive_medium: assert property (@(posedge clock) disable iff (reset)
    s_q.enable && s_q.range == 2'h2 |=> driveMedium && !driveLow && !driveHigh)
    else $error("medium range did not select medium drive");
  a_noise_mode: assert property (@(posedge clock) disable iff (reset)
    s_q.enable && s_q.refVariable && s_q.range == 2'h0 |=> noiseDetect && oscillatorOn
      && !driveLow && !driveMedium && !driveHigh)
    else $error("noise detection mode wrong");
  a_fixed_off: assert property (@(posedge clock) disable iff (reset)
    !s_q.refVariable && s_q.range == 2'h0 |=> !oscillatorOn && !noiseDetect)
    else $error("fixed range code zero left oscillator on");
  a_chan_select: assert property (@(posedge clock) disable iff (reset)
    s_q.enable && s_q.channel <= 4'hb |=> $onehot(channelSelect)
      && channelSelect[$past(s_q.channel)])
    else $error("valid channel not selected");
  a_chan_none: assert property (@(posedge clock) disable iff (reset)
    !s_q.enable || s_q.channel > 4'hb |=> channelSelect == 12'h000)
    else $error("channel selected while disabled or reserved");
  a_status_off: assert property (@(posedge clock) disable iff (reset)
    !s_q.oscOn |=> !s_q.status)
    else $error("drive status set while oscillator off");
  a_b_stopped: assert property (@(posedge clock) disable iff (reset)
    !s_q.bOn && !wrTimerB |=> s_q.bCount == $past(s_q.bCount))
    else $error("timer B counted while off");
  a_b_osc_count: assert property (@(posedge clock) disable iff (reset)
    s_q.bOn && !s_q.bGateEnable && s_q.bSource == 2'h3 && oscRise && !wrTimerB
      |=> s_q.bCount == $past(s_q.bCount) + 16'h0001)
    else $error("timer B missed an oscillator edge");
  a_a_osc_count: assert property (@(posedge clock) disable iff (reset)
    s_q.aSource && s_q.aExtSelect && !oscRise && !writeMapped
      |=> s_q.aCount == $past(s_q.aCount))
    else $error("timer A counted without an oscillator edge");

endmodule : cap_sense_control

// *** cap_sense_pkg.sv ***
// Constants for the capacitive touch sense control block.
// Assumes a 32-bit AXI4-Lite register bus on one 100 MHz clock.
package cap_sense_pkg;

  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] SENSE_CONTROL_0_OFFSET = 8'h00;
  localparam logic [7:0] SENSE_CONTROL_1_OFFSET = 8'h04;
  localparam logic [7:0] TIMER_A_CONTROL_OFFSET = 8'h08;
  localparam logic [7:0] TIMER_A_COUNT_OFFSET = 8'h0c;
  localparam logic [7:0] TIMER_B_CONTROL_OFFSET = 8'h10;
  localparam logic [7:0] TIMER_B_COUNT_OFFSET = 8'h14;

  // ==========================================================================
  // Field positions, sense_control_0
  localparam int MODULE_ENABLE_BIT = 7;
  localparam int REFERENCE_MODE_BIT = 6;
  localparam int CURRENT_RANGE_LSB = 2;
  localparam int DRIVE_STATUS_BIT = 1;
  localparam int TIMER_A_EXT_SELECT_BIT = 0;
  // Timer A control
  localparam int TIMER_A_SOURCE_BIT = 0;
  localparam int TIMER_A_OVERFLOW_BIT = 1;
  // Timer B control
  localparam int TIMER_B_SOURCE_LSB = 6;
  localparam int TIMER_B_GATE_ENABLE_BIT = 2;
  localparam int TIMER_B_ON_BIT = 0;

  // ==========================================================================
  // Codes and widths
  localparam logic [1:0] RANGE_OFF_OR_NOISE = 2'h0;
  localparam logic [1:0] RANGE_LOW = 2'h1;
  localparam logic [1:0] RANGE_MEDIUM = 2'h2;
  localparam logic [1:0] RANGE_HIGH = 2'h3;
  localparam logic [3:0] LAST_CHANNEL = 4'hb;
  localparam int CHANNEL_COUNT = 12;
  localparam logic [1:0] TIMER_B_SRC_QUARTER = 2'h0;
  localparam logic [1:0] TIMER_B_SRC_SYSTEM = 2'h1;
  localparam logic [1:0] TIMER_B_SRC_PIN = 2'h2;
  localparam logic [1:0] TIMER_B_SRC_OSCILLATOR = 2'h3;
  localparam logic [1:0] PRESCALE_LAST = 2'h3;
  localparam int TIMER_A_WIDTH = 8;
  localparam int TIMER_B_WIDTH = 16;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================================
  // Reset values
  localparam logic [31:0] REGISTER_RESET = 32'h0000_0000;

endpackage : cap_sense_pkg

// *** sync_two_flop.sv ***
// Two-flop synchroniser for a bundle of independent levels.
// Assumes each bit is a slow level or a clock far below the system clock.
module sync_two_flop #(
  parameter int WIDTH = 1
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic [WIDTH-1:0] async,
  output logic [WIDTH-1:0] synced
);

  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clock) begin
    if (reset) begin
      meta_q <= '0;
      synced <= '0;
    end else begin
      meta_q <= async;
      synced <= meta_q;
    end
  end

endmodule : sync_two_flop

// *** touch_pad_model.sv ***
// Behavioural touch pad and oscillator comparator on the far side of the sense mux.
// Assumes the comparator runs on its own timing, unrelated to the system clock.
module touch_pad_model (
  input wire logic oscillatorOn,
  input wire logic noiseDetect,
  input wire logic [11:0] channelSelect,
  input wire logic touched,
  input wire logic stall,
  input wire logic stallLevel,
  output logic oscillatorComparator
);
  timeunit 1ns;
  timeprecision 100ps;
  logic running;
  // ==========================================================================
  // Triangle wave
  // Swings only with current flowing and a pin connected
  assign running = oscillatorOn && !noiseDetect && (channelSelect != 12'h000);
  initial begin
    oscillatorComparator = 1'b0;
    forever begin
      // Extra finger load slows the swing
      #(touched ? 73.3 : 41.7);
      if (stall) begin
        oscillatorComparator = stallLevel;
      end else if (running) begin
        oscillatorComparator = ~oscillatorComparator;
      end
    end
  end
endmodule : touch_pad_model

// *** testbench.sv ***
// Self-checking bench for the capacitive sense control block.
// Assumes the register map and response codes of cap_sense_pkg.
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] CTRL0 = cap_sense_pkg::SENSE_CONTROL_0_OFFSET;
  localparam logic [7:0] CTRL1 = cap_sense_pkg::SENSE_CONTROL_1_OFFSET;
  localparam logic [7:0] TA_CTRL = cap_sense_pkg::TIMER_A_CONTROL_OFFSET;
  localparam logic [7:0] TA_CNT = cap_sense_pkg::TIMER_A_COUNT_OFFSET;
  localparam logic [7:0] TB_CTRL = cap_sense_pkg::TIMER_B_CONTROL_OFFSET;
  localparam logic [7:0] TB_CNT = cap_sense_pkg::TIMER_B_COUNT_OFFSET;
  localparam logic [1:0] OK = cap_sense_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = cap_sense_pkg::RESP_SLVERR;
  typedef struct {logic [31:0] d; logic [1:0] r; bit ne;} rexp_t;
  logic clock, awready, wready, bvalid, arready, rvalid, oscillatorComparator;
  logic reset = 1'b1, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, timerPin = 1'b0, timerBGate = 1'b0;
  logic touched = 1'b0, stall = 1'b1, stallLevel = 1'b0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata;
  logic [3:0] wstrb = 4'h0;
  logic [1:0] bresp, rresp;
  logic oscillatorOn, noiseDetect, driveLow, driveMedium, driveHigh;
  logic lowRefFromDac, highRefFromFvr, timerAOscClock, timerBOscClock, timerBRunning;
  logic [11:0] channelSelect;
  logic [6:0] ctl;
  int failCount = 0;
  int numChecks = 0;
  rexp_t rq[$];
  rexp_t re;
  logic [31:0] lastRead = 32'h0;
  logic [1:0] bq[$];

  cap_sense_control uut (.clock, .reset, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .oscillatorComparator, .timerPin, .timerBGate,
    .oscillatorOn, .noiseDetect, .driveLow, .driveMedium, .driveHigh, .lowRefFromDac,
    .highRefFromFvr, .channelSelect, .timerAOscClock, .timerBOscClock, .timerBRunning);
  touch_pad_model pad (.oscillatorOn, .noiseDetect, .channelSelect, .touched, .stall,
    .stallLevel, .oscillatorComparator);

  assign ctl = {oscillatorOn, noiseDetect, driveLow, driveMedium, driveHigh,
    lowRefFromDac, highRefFromFvr};

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // ==========================================================================
  // Checking
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    numChecks++;
    if (g !== e) begin
      failCount++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic giveVerdict();
    if (failCount == 0 && numChecks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : giveVerdict

  task automatic stuck();
    chk("handshake wait", 32'h0, 32'h1);
    giveVerdict();
  endtask : stuck

  // Oldest note is matched to each response as it is consumed
  always @(posedge clock) begin
    if (bvalid && bready) begin
      chk("write response", {30'h0, bq.pop_front()}, {30'h0, bresp});
    end
    if (rvalid && rready) begin
      re = rq.pop_front();
      chk("read data", re.ne ? 32'h1 : re.d, re.ne ? {31'h0, rdata !== re.d} : rdata);
      chk("read response", {30'h0, re.r}, {30'h0, rresp});
    end
  end

  // ==========================================================================
  // Bus master
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] r);
    bit pa = 1'b1;
    bit pw = 1'b1;
    bit pb = 1'b1;
    int n = 0;
    @(posedge clock);
    bq.push_back(r);
    awaddr <= {24'h000000, a};
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (pb && n < 50) begin
      @(posedge clock);
      n++;
      if (pa && awready) begin
        pa = 1'b0;
        awvalid <= 1'b0;
      end
      if (pw && wready) begin
        pw = 1'b0;
        wvalid <= 1'b0;
      end
      if (bvalid) begin
        pb = 1'b0;
        bready <= 1'b0;
      end
    end
    if (pb) stuck();
  endtask : wr

  // A set ne bit expects the data to differ from d
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r,
                    input bit ne = 1'b0);
    bit pa = 1'b1;
    bit pr = 1'b1;
    int n = 0;
    @(posedge clock);
    rq.push_back('{d, r, ne});
    araddr <= {24'h000000, a};
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (pr && n < 50) begin
      @(posedge clock);
      n++;
      if (pa && arready) begin
        pa = 1'b0;
        arvalid <= 1'b0;
      end
      if (rvalid) begin
        pr = 1'b0;
        lastRead = rdata;
        rready <= 1'b0;
      end
    end
    if (pr) stuck();
  endtask : rd

  // ==========================================================================
  // Scenarios
  initial begin
    logic [31:0] v;
    logic en, m;
    logic [1:0] r;
    logic [31:0] cnt [2];
    void'($urandom(7));
    repeat (10) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    chk("outputs after reset", 32'h0, {25'h0, ctl});
    // Timer A counts freely from reset, so only control registers are read here
    for (int i = 0; i < 6; i++) begin
      if (i != 3 && i != 5) rd(8'(4 * i), 32'h0, OK);
    end
    for (int k = 0; k < 16; k++) begin
      en = k[3];
      m = k[2];
      r = k[1:0];
      v = {24'h000000, en, m, 2'b00, r, 2'b00};
      wr(CTRL0, v, 4'hf, OK);
      rd(CTRL0, v, OK);
      chk("control outputs", {25'h0, en && (m || r != 2'h0), en && m && r == 2'h0,
        en && r == 2'h1, en && r == 2'h2, en && r == 2'h3, m, m}, {25'h0, ctl});
    end
    wr(CTRL0, 32'h8c, 4'hf, OK);
    for (int c = 0; c < 16; c++) begin
      wr(CTRL1, 32'hfffffff0 | 32'(c), 4'hf, OK);
      rd(CTRL1, 32'(c), OK);
      chk("channel select", c < 12 ? 32'h1 << c : 32'h0, {20'h0, channelSelect});
    end
    wr(CTRL1, 32'h3, 4'hf, OK);
    wr(CTRL0, 32'h0c, 4'hf, OK);
    wr(CTRL1, 32'h7, 4'h0, OK);
    rd(CTRL1, 32'h3, OK);
    chk("channel select", 32'h0, {20'h0, channelSelect});
    wr(CTRL0, 32'h8c, 4'hf, OK);
    stallLevel <= 1'b1;
    repeat (20) @(posedge clock);
    rd(CTRL0, 32'h8e, OK);
    chk("channel select", 32'h8, {20'h0, channelSelect});
    wr(CTRL0, 32'hc0, 4'hf, OK);
    rd(CTRL0, 32'hc0, OK);
    wr(CTRL0, 32'h8c, 4'hf, OK);
    stallLevel <= 1'b0;
    repeat (20) @(posedge clock);
    rd(CTRL0, 32'h8c, OK);
    // Oscillator swings while timer A must still follow the pin
    stall <= 1'b0;
    wr(TA_CTRL, 32'h1, 4'hf, OK);
    v = $urandom;
    wr(TA_CNT, v, 4'hf, OK);
    repeat (5) begin
      timerPin <= 1'b1;
      repeat (4) @(posedge clock);
      timerPin <= 1'b0;
      repeat (4) @(posedge clock);
    end
    repeat (6) @(posedge clock);
    rd(TA_CNT, (v + 32'h5) & 32'hff, OK);
    chk("timer a osc clock", 32'h0, {31'h0, timerAOscClock});
    touched <= 1'b1;
    wr(CTRL0, 32'h8d, 4'hf, OK);
    wr(TA_CNT, 32'h0, 4'hf, OK);
    repeat (100) @(posedge clock);
    rd(TA_CNT, 32'h0, OK, 1'b1);
    chk("timer a osc clock", 32'h1, {31'h0, timerAOscClock});
    v = $urandom & 32'hffff;
    wr(TB_CTRL, 32'h0, 4'hf, OK);
    wr(TB_CNT, v, 4'hf, OK);
    repeat (60) @(posedge clock);
    rd(TB_CNT, v, OK);
    chk("timer b flags", 32'h0, {30'h0, timerBOscClock, timerBRunning});
    wr(TB_CTRL, 32'hc5, 4'hf, OK);
    repeat (60) @(posedge clock);
    rd(TB_CNT, v, OK);
    chk("timer b flags", 32'h3, {30'h0, timerBOscClock, timerBRunning});
    timerBGate <= 1'b1;
    repeat (100) @(posedge clock);
    rd(TB_CNT, v, OK, 1'b1);
    timerBGate <= 1'b0;
    wr(TB_CTRL, 32'hc1, 4'hf, OK);
    wr(TB_CNT, 32'h0, 4'hf, OK);
    repeat (100) @(posedge clock);
    rd(TB_CNT, 32'h0, OK, 1'b1);
    // Time base from timer A overflow; gate on timer B brackets the oscillator count
    wr(TB_CTRL, 32'hc5, 4'hf, OK);
    for (int t = 0; t < 2; t++) begin
      touched <= t[0];
      wr(TA_CTRL, 32'h2, 4'hf, OK);
      wr(TB_CNT, 32'h0, 4'hf, OK);
      wr(TA_CNT, 32'h0, 4'hf, OK);
      timerBGate <= 1'b1;
      repeat (1024) @(posedge clock);
      rd(TA_CTRL, 32'h2, OK);
      timerBGate <= 1'b0;
      repeat (4) @(posedge clock);
      rd(TB_CNT, 32'h0, OK, 1'b1);
      cnt[t] = lastRead;
    end
    // About 10.27 us of gate over an 83.4 ns or 146.6 ns swing
    chk("idle count", 32'h1, {31'h0, cnt[0] >= 32'd120 && cnt[0] <= 32'd126});
    chk("loaded count", 32'h1, {31'h0, cnt[1] >= 32'd67 && cnt[1] <= 32'd73});
    chk("touch threshold", 32'h1, {31'h0, (cnt[1] < (cnt[0] + cnt[1]) / 2) &&
      (cnt[0] > (cnt[0] + cnt[1]) / 2)});
    wr(8'h18, 32'hffffffff, 4'hf, ERR);
    rd(8'h18, 32'h0, ERR);
    giveVerdict();
  end
endmodule : testbench
